/* src/dcc_cap_chan.sv */
// One capture channel: edge detect, result latch and sticky status.
// Assumes the source input is synchronous to clk.
module dcc_cap_chan
	import dcc_pkg::*;
(
	// Clock and reset
	input  wire logic                   clk,
	input  wire logic                   reset,
	// Configuration and bus writes
	input  wire dcc_pkg::dcc_chan_cfg_t cfg,
	input  wire dcc_pkg::dcc_chan_wr_t  wr,
	// Source and live count
	input  wire logic                   src_in,
	input  wire logic [15:0]            count,
	// Results
	output logic [15:0]                 cap_r,
	output logic                        sts_r
);
	logic src_prev_r; // Source one cycle ago
	logic rise;       // Rising edge seen
	logic fall;       // Falling edge seen
	logic trig;       // Qualified capture event

	////////////////////////////////////////////////////////////////////
	// Edge detection and qualification
	assign rise = src_in & ~src_prev_r;
	assign fall = ~src_in & src_prev_r;
	always_comb begin
		if (!cfg.en) begin
			trig = 1'b0;
		end else if (cfg.edge_sel[EDGE_BOTH_BIT]) begin
			trig = rise | fall;
		end else if (cfg.edge_sel == EDGE_RISE) begin
			trig = rise;
		end else begin
			trig = fall;
		end
	end

	// Previous source level
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			src_prev_r <= 1'b0;
		end else begin
			src_prev_r <= src_in;
		end
	end

	// Result latch; a capture wins over a bus write
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			cap_r <= {RST_BYTE, RST_BYTE};
		end else if (trig) begin
			cap_r <= count;
		end else begin
			if (wr.wr_lo) cap_r[7:0] <= wr.data;
			if (wr.wr_hi) cap_r[15:8] <= wr.data;
		end
	end

	// Sticky status; set wins over a clear
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			sts_r <= 1'b0;
		end else if (trig) begin
			sts_r <= 1'b1;
		end else if (wr.clr_sts) begin
			sts_r <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Checks
	AST_CAP: assert property (@(posedge clk) disable iff (reset)
		trig |=> (cap_r == $past(count) && sts_r))
		else $error("capture did not latch count");
	AST_OFF: assert property (@(posedge clk) disable iff (reset)
		(!cfg.en && !sts_r) |=> !sts_r)
		else $error("disabled source set status");
	AST_HOLD: assert property (@(posedge clk) disable iff (reset)
		(sts_r && !wr.clr_sts) |=> sts_r)
		else $error("status lost without clear");
	AST_EDGE: assert property (@(posedge clk) disable iff (reset)
		(cfg.edge_sel == EDGE_RISE && fall) |-> !trig)
		else $error("rising mode fired on falling edge");

endmodule : dcc_cap_chan

/* src/dcc_pkg.sv */
// Constants and types for the six-source capture down-counter.
// Assumes one clock; register indices are word indices on AXI4-Lite.
package dcc_pkg;

	////////////////////////////////////////////////////////////////////
	// Bus widths and responses
	localparam int          ADDR_W      = 12;    // Byte address width
	localparam logic [1:0]  RESP_OKAY   = 2'h0;  // Normal answer
	localparam logic [1:0]  RESP_SLVERR = 2'h2;  // Unmapped address

	////////////////////////////////////////////////////////////////////
	// Register indices (byte address is four times the index)
	localparam logic [7:0] IDX_CTRL      = 8'hba; // Control
	localparam logic [7:0] IDX_RELOAD_LO = 8'hbb; // reload_value_low
	localparam logic [7:0] IDX_RELOAD_HI = 8'hbc; // reload_value_high
	localparam logic [7:0] IDX_COUNT_LO  = 8'hbd; // count_value_low
	localparam logic [7:0] IDX_COUNT_HI  = 8'hbe; // count_value_high
	localparam logic [7:0] IDX_CAP_EN    = 8'hbf; // capture_source_enable
	localparam logic [7:0] IDX_EDGE_PIN  = 8'hc2; // capture_edge_select_pins
	localparam logic [7:0] IDX_EDGE_CMP  = 8'hc3; // capture_edge_select_comparator
	localparam logic [7:0] IDX_CAP_IE    = 8'hc4; // capture_irq_enable
	localparam logic [7:0] IDX_CAP_STS   = 8'hc5; // capture_irq_status

	// Capture result indices, one per source
	localparam int         NUM_CAP = 6;
	localparam logic [7:0] CAP_LO_IDX [NUM_CAP] = '{8'hc6, 8'hca, 8'hcc, 8'hce, 8'hd1, 8'hd3};
	localparam logic [7:0] CAP_HI_IDX [NUM_CAP] = '{8'hc7, 8'hcb, 8'hcd, 8'hcf, 8'hd2, 8'hd4};

	////////////////////////////////////////////////////////////////////
	// Control register fields
	localparam int CTRL_RUN_BIT  = 0; // counter_run_enable
	localparam int CTRL_SEL_LSB  = 1; // tick_source_select[2:0]
	localparam int CTRL_IEN_BIT  = 4; // Counter interrupt enable
	localparam int CTRL_FLAG_BIT = 5; // counter_irq_flag

	// Reset value of every register
	localparam logic [7:0] RST_BYTE = 8'h00;

	////////////////////////////////////////////////////////////////////
	// Tick source codes and prescaler masks
	localparam logic [2:0] SEL_SYS     = 3'h0; // System clock
	localparam logic [2:0] SEL_BAD     = 3'h7; // Prohibited code
	localparam logic [9:0] MASK_DIV2   = 10'h001;
	localparam logic [9:0] MASK_DIV4   = 10'h003;
	localparam logic [9:0] MASK_DIV128 = 10'h07f;
	localparam logic [9:0] MASK_DIV256 = 10'h0ff;
	localparam logic [9:0] MASK_DIV512 = 10'h1ff;
	localparam logic [9:0] MASK_DIV1K  = 10'h3ff;

	// Edge selector codes; upper bit set means both edges
	localparam logic [1:0] EDGE_FALL = 2'h0;
	localparam logic [1:0] EDGE_RISE = 2'h1;
	localparam int         EDGE_BOTH_BIT = 1;

	////////////////////////////////////////////////////////////////////
	// Per-channel configuration
	typedef struct packed {
		logic       en;       // Source enable
		logic [1:0] edge_sel; // Edge selector
	} dcc_chan_cfg_t;

	// Per-channel bus write strobes
	typedef struct packed {
		logic       clr_sts;  // Status byte written with bit zero
		logic       wr_lo;    // Low result byte written
		logic       wr_hi;    // High result byte written
		logic [7:0] data;     // Write byte
	} dcc_chan_wr_t;

endpackage : dcc_pkg

/* src/dcc_top.sv */
// Functional notes
// - Counter runs only while run bit set
// - Sixteen-bit reload value, two byte registers
// - Live count readable and writable bytewise
// - Six capture enables: pins, comparator up/down
// - Edge code: 00 fall, 01 rise, 1x both
// - Edge fields: pins register, comparator register
// - Six interrupt enables, capture enable order
// - Status set on capture; write zero clears
// - Six sixteen-bit capture results, read/write bytes
// - Decrement per tick; zero reloads, sets flag
// - Trigger latches count into firing source
// - Three-bit tick divider select; 111 prohibited
//
// Top of the six-source capture down-counter with AXI4-Lite slave.
// Assumes pins and comparator events are synchronous to clk.
module dcc_top
	import dcc_pkg::*;
(
	// Clock and reset
	input  wire logic                      clk,
	input  wire logic                      reset,
	// AXI4-Lite write address
	input  wire logic [dcc_pkg::ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                      s_axi_awvalid,
	output logic                           s_axi_awready,
	// AXI4-Lite write data
	input  wire logic [31:0]               s_axi_wdata,
	input  wire logic [3:0]                s_axi_wstrb,
	input  wire logic                      s_axi_wvalid,
	output logic                           s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0]                     s_axi_bresp,
	output logic                           s_axi_bvalid,
	input  wire logic                      s_axi_bready,
	// AXI4-Lite read
	input  wire logic [dcc_pkg::ADDR_W-1:0] s_axi_araddr,
	input  wire logic                      s_axi_arvalid,
	output logic                           s_axi_arready,
	output logic [31:0]                    s_axi_rdata,
	output logic [1:0]                     s_axi_rresp,
	output logic                           s_axi_rvalid,
	input  wire logic                      s_axi_rready,
	// Capture sources
	input  wire logic [3:0]                cap_pin_in,
	input  wire logic                      comparator_up_event,
	input  wire logic                      comparator_down_event,
	// Interrupt
	output logic                           irq
);
	////////////////////////////////////////////////////////////////////
	// Declarations
	logic        awready_r, wready_r;  // Channel readies
	logic        aw_held_r, w_held_r;  // Address and data latched
	logic [7:0]  wr_idx_r;             // Latched write index
	logic [7:0]  wbyte_r;              // Latched write byte
	logic        wstrb0_r;             // Low lane strobe
	logic        bvalid_r;             // Write answer pending
	logic [1:0]  bresp_r;              // Write answer code
	logic        arready_r, rvalid_r;  // Read handshake
	logic [31:0] rdata_r;              // Read data
	logic [1:0]  rresp_r;              // Read answer code
	logic        irq_r;                // Interrupt output
	logic        wr_go;                // Write performed this cycle
	logic        we;                   // Write hits low byte lane
	logic        wr_hit;               // Write index mapped
	logic        rd_hit;               // Read index mapped
	logic [7:0]  rd_byte;              // Read mux result
	logic [7:0]  rd_idx;               // Read index
	logic        run_r;                // counter_run_enable
	logic [2:0]  tick_sel_r;           // tick_source_select
	logic        cnt_ien_r;            // Counter interrupt enable
	logic        cnt_flag_r;           // counter_irq_flag
	logic [15:0] reload_r;             // Reload value
	logic [15:0] count_r;              // Live count
	logic [5:0]  cap_en_r;             // capture_source_enable
	logic [7:0]  edge_pin_r;           // Pin edge selectors
	logic [3:0]  edge_cmp_r;           // Comparator edge selectors
	logic [5:0]  cap_ie_r;             // capture_irq_enable
	logic [9:0]  pre_r;                // Prescaler
	logic [9:0]  pre_mask;             // Prescaler mask
	logic        tick;                 // Count tick
	logic        cnt_wr;               // Software writes count
	logic [5:0]  src;                  // Source vector
	logic [11:0] edge_all;             // All edge selectors
	logic [5:0]  cap_sts;              // Channel status bits
	logic [15:0] cap_val [NUM_CAP];    // Channel results

	////////////////////////////////////////////////////////////////////
	// Bus outputs come straight from flops
	assign s_axi_awready = awready_r;
	assign s_axi_wready  = wready_r;
	assign s_axi_bvalid  = bvalid_r;
	assign s_axi_bresp   = bresp_r;
	assign s_axi_arready = arready_r;
	assign s_axi_rvalid  = rvalid_r;
	assign s_axi_rdata   = rdata_r;
	assign s_axi_rresp   = rresp_r;
	assign irq           = irq_r;

	// Write performed once both halves are held
	assign wr_go = aw_held_r & w_held_r & ~bvalid_r;
	assign we    = wr_go & wstrb0_r;

	////////////////////////////////////////////////////////////////////
	// Write address channel
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			awready_r <= 1'b1;
			aw_held_r <= 1'b0;
			wr_idx_r  <= RST_BYTE;
		end else if (s_axi_awvalid && awready_r) begin
			awready_r <= 1'b0;
			aw_held_r <= 1'b1;
			wr_idx_r  <= s_axi_awaddr[9:2];
		end else if (wr_go) begin
			aw_held_r <= 1'b0;
		end else if (bvalid_r && s_axi_bready) begin
			awready_r <= 1'b1;
		end
	end

	// Write data channel
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			wready_r <= 1'b1;
			w_held_r <= 1'b0;
			wbyte_r  <= RST_BYTE;
			wstrb0_r <= 1'b0;
		end else if (s_axi_wvalid && wready_r) begin
			wready_r <= 1'b0;
			w_held_r <= 1'b1;
			wbyte_r  <= s_axi_wdata[7:0];
			wstrb0_r <= s_axi_wstrb[0];
		end else if (wr_go) begin
			w_held_r <= 1'b0;
		end else if (bvalid_r && s_axi_bready) begin
			wready_r <= 1'b1;
		end
	end

	// Write response
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			bvalid_r <= 1'b0;
			bresp_r  <= RESP_OKAY;
		end else if (wr_go) begin
			bvalid_r <= 1'b1;
			bresp_r  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_r <= 1'b0;
		end
	end

	// Write index decode
	always_comb begin
		wr_hit = 1'b0;
		if (wr_idx_r == IDX_CTRL || wr_idx_r == IDX_RELOAD_LO) begin
			wr_hit = 1'b1;
		end else if (wr_idx_r == IDX_RELOAD_HI || wr_idx_r == IDX_COUNT_LO) begin
			wr_hit = 1'b1;
		end else if (wr_idx_r == IDX_COUNT_HI || wr_idx_r == IDX_CAP_EN) begin
			wr_hit = 1'b1;
		end else if (wr_idx_r == IDX_EDGE_PIN || wr_idx_r == IDX_EDGE_CMP) begin
			wr_hit = 1'b1;
		end else if (wr_idx_r == IDX_CAP_IE || wr_idx_r == IDX_CAP_STS) begin
			wr_hit = 1'b1;
		end
		for (int k = 0; k < NUM_CAP; k++) begin
			if (wr_idx_r == CAP_LO_IDX[k] || wr_idx_r == CAP_HI_IDX[k]) begin
				wr_hit = 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Read channel
	assign rd_idx = s_axi_araddr[9:2];

	// Read mux over mapped indices; unmapped reads zero
	always_comb begin
		rd_hit  = 1'b1;
		rd_byte = RST_BYTE;
		if (rd_idx == IDX_CTRL) begin
			rd_byte = {2'h0, cnt_flag_r, cnt_ien_r, tick_sel_r, run_r};
		end else if (rd_idx == IDX_RELOAD_LO) begin
			rd_byte = reload_r[7:0];
		end else if (rd_idx == IDX_RELOAD_HI) begin
			rd_byte = reload_r[15:8];
		end else if (rd_idx == IDX_COUNT_LO) begin
			rd_byte = count_r[7:0];
		end else if (rd_idx == IDX_COUNT_HI) begin
			rd_byte = count_r[15:8];
		end else if (rd_idx == IDX_CAP_EN) begin
			rd_byte = {2'h0, cap_en_r};
		end else if (rd_idx == IDX_EDGE_PIN) begin
			rd_byte = edge_pin_r;
		end else if (rd_idx == IDX_EDGE_CMP) begin
			rd_byte = {4'h0, edge_cmp_r};
		end else if (rd_idx == IDX_CAP_IE) begin
			rd_byte = {2'h0, cap_ie_r};
		end else if (rd_idx == IDX_CAP_STS) begin
			rd_byte = {2'h0, cap_sts};
		end else begin
			rd_hit = 1'b0;
		end
		for (int k = 0; k < NUM_CAP; k++) begin
			if (rd_idx == CAP_LO_IDX[k]) begin
				rd_hit  = 1'b1;
				rd_byte = cap_val[k][7:0];
			end else if (rd_idx == CAP_HI_IDX[k]) begin
				rd_hit  = 1'b1;
				rd_byte = cap_val[k][15:8];
			end
		end
	end

	// Read handshake: answer one cycle after the address is taken
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			arready_r <= 1'b1;
			rvalid_r  <= 1'b0;
			rdata_r   <= 32'h0000_0000;
			rresp_r   <= RESP_OKAY;
		end else if (s_axi_arvalid && arready_r) begin
			arready_r <= 1'b0;
			rvalid_r  <= 1'b1;
			rdata_r   <= {24'h00_0000, rd_byte};
			rresp_r   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (rvalid_r && s_axi_rready) begin
			arready_r <= 1'b1;
			rvalid_r  <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Control register
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			run_r      <= 1'b0;
			tick_sel_r <= SEL_SYS;
			cnt_ien_r  <= 1'b0;
		end else if (we && wr_idx_r == IDX_CTRL) begin
			run_r      <= wbyte_r[CTRL_RUN_BIT];
			tick_sel_r <= wbyte_r[CTRL_SEL_LSB +: 3];
			cnt_ien_r  <= wbyte_r[CTRL_IEN_BIT];
		end
	end

	// Configuration registers
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			reload_r   <= {RST_BYTE, RST_BYTE};
			cap_en_r   <= 6'h00;
			edge_pin_r <= RST_BYTE;
			edge_cmp_r <= 4'h0;
			cap_ie_r   <= 6'h00;
		end else if (we) begin
			if (wr_idx_r == IDX_RELOAD_LO) begin
				reload_r[7:0] <= wbyte_r;
			end else if (wr_idx_r == IDX_RELOAD_HI) begin
				reload_r[15:8] <= wbyte_r;
			end else if (wr_idx_r == IDX_CAP_EN) begin
				cap_en_r <= wbyte_r[5:0];
			end else if (wr_idx_r == IDX_EDGE_PIN) begin
				edge_pin_r <= wbyte_r;
			end else if (wr_idx_r == IDX_EDGE_CMP) begin
				edge_cmp_r <= wbyte_r[3:0];
			end else if (wr_idx_r == IDX_CAP_IE) begin
				cap_ie_r <= wbyte_r[5:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Tick prescaler
	always_comb begin
		case (tick_sel_r)
			3'h1:    pre_mask = MASK_DIV2;
			3'h2:    pre_mask = MASK_DIV4;
			3'h3:    pre_mask = MASK_DIV128;
			3'h4:    pre_mask = MASK_DIV256;
			3'h5:    pre_mask = MASK_DIV512;
			default: pre_mask = MASK_DIV1K;
		endcase
	end

	// Prescaler runs only while the counter runs
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			pre_r <= 10'h000;
		end else if (run_r) begin
			pre_r <= pre_r + 10'h001;
		end else begin
			pre_r <= 10'h000;
		end
	end

	// Tick: every clock, divided, or never for the prohibited code
	always_comb begin
		if (tick_sel_r == SEL_BAD) begin
			tick = 1'b0;
		end else if (tick_sel_r == SEL_SYS) begin
			tick = 1'b1;
		end else begin
			tick = (pre_r & pre_mask) == pre_mask;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Down-counter; a software write wins over a tick
	assign cnt_wr = we && (wr_idx_r == IDX_COUNT_LO || wr_idx_r == IDX_COUNT_HI);

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			count_r <= {RST_BYTE, RST_BYTE};
		end else if (cnt_wr) begin
			if (wr_idx_r == IDX_COUNT_LO) count_r[7:0] <= wbyte_r;
			else count_r[15:8] <= wbyte_r;
		end else if (run_r && tick) begin
			if (count_r == 16'h0000) count_r <= reload_r;
			else count_r <= count_r - 16'h0001;
		end
	end

	// Counter flag: set at reload, written zero clears, set wins
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			cnt_flag_r <= 1'b0;
		end else if (run_r && tick && !cnt_wr && count_r == 16'h0000) begin
			cnt_flag_r <= 1'b1;
		end else if (we && wr_idx_r == IDX_CTRL && !wbyte_r[CTRL_FLAG_BIT]) begin
			cnt_flag_r <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Capture channels
	assign src      = {comparator_down_event, comparator_up_event, cap_pin_in};
	assign edge_all = {edge_cmp_r, edge_pin_r};

	for (genvar i = 0; i < NUM_CAP; i++) begin : g_chan
		dcc_chan_cfg_t cfg; // Channel configuration
		dcc_chan_wr_t  wr;  // Channel write strobes

		assign cfg.en       = cap_en_r[i];
		assign cfg.edge_sel = edge_all[2*i +: 2];
		assign wr.clr_sts   = we && wr_idx_r == IDX_CAP_STS && !wbyte_r[i];
		assign wr.wr_lo     = we && wr_idx_r == CAP_LO_IDX[i];
		assign wr.wr_hi     = we && wr_idx_r == CAP_HI_IDX[i];
		assign wr.data      = wbyte_r;

		dcc_cap_chan u_chan (
			.clk    (clk),
			.reset  (reset),
			.cfg    (cfg),
			.wr     (wr),
			.src_in (src[i]),
			.count  (count_r),
			.cap_r  (cap_val[i]),
			.sts_r  (cap_sts[i])
		);
	end

	////////////////////////////////////////////////////////////////////
	// Interrupt output
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			irq_r <= 1'b0;
		end else begin
			irq_r <= (|(cap_sts & cap_ie_r)) | (cnt_flag_r & cnt_ien_r);
		end
	end

	////////////////////////////////////////////////////////////////////
	// Checks
	AST_STOP: assert property (@(posedge clk) disable iff (reset)
		(!run_r && !cnt_wr) |=> $stable(count_r))
		else $error("count moved while stopped");
	AST_RELOAD: assert property (@(posedge clk) disable iff (reset)
		(run_r && tick && !cnt_wr && count_r == 16'h0000)
		|=> (count_r == $past(reload_r) && cnt_flag_r))
		else $error("zero did not reload and flag");
	AST_DEC: assert property (@(posedge clk) disable iff (reset)
		(run_r && tick && !cnt_wr && count_r != 16'h0000)
		|=> count_r == $past(count_r) - 16'h0001)
		else $error("count did not decrement");
	AST_NOTICK: assert property (@(posedge clk) disable iff (reset)
		(tick_sel_r == SEL_BAD) |-> !tick)
		else $error("prohibited code ticked");
	AST_DIV2: assert property (@(posedge clk) disable iff (reset)
		(run_r && tick_sel_r == 3'h1 && tick) ##1 (tick_sel_r == 3'h1) |-> !tick)
		else $error("divide by two ticked twice in a row");
	AST_IRQ: assert property (@(posedge clk) disable iff (reset)
		(|(cap_sts & cap_ie_r)) |=> irq_r)
		else $error("enabled status raised no interrupt");
	AST_BRESP: assert property (@(posedge clk) disable iff (reset)
		wr_go |=> (bvalid_r && !aw_held_r && !w_held_r))
		else $error("write not answered next cycle");
	AST_RDATA: assert property (@(posedge clk) disable iff (reset)
		(s_axi_arvalid && arready_r) |=> (rvalid_r && !arready_r))
		else $error("read not answered next cycle");

endmodule : dcc_top

/* tb/dcc_src_model.sv */
// Far-side model: four capture pins and two comparator event lines.
// Assumes the bench requests levels; lines change right after clk edges.
module dcc_src_model (
	// Clock and requested levels
	input  wire logic       clk,
	input  wire logic [5:0] want,
	// Source lines
	output logic [3:0]      pin,
	output logic            up_evt,
	output logic            dn_evt
);
	timeunit 1ns;
	timeprecision 100ps;

	////////////////////////////////////////////////////////////////////
	// Quiet lines at time zero, before the first edge
	initial {dn_evt, up_evt, pin} = '0;

	// Sources 0-3 on pins, 4 on comparator up, 5 on comparator down
	always @(posedge clk) begin
		pin    <= want[3:0];
		up_evt <= want[4];
		dn_evt <= want[5];
	end
endmodule : dcc_src_model

/* tb/dcc_top_test.sv */
// Self-checking bench for the capture down-counter over AXI4-Lite.
// Assumes dcc_src_model drives the capture sources.
module dcc_top_test;
	timeunit 1ns;
	timeprecision 100ps;
	import dcc_pkg::*;

	////////////////////////////////////////////////////////////////////
	// Bus, source and bookkeeping signals
	logic        clk = 0, reset = 1, irq;
	logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [31:0] s_axi_wdata = '0, s_axi_rdata;
	logic [3:0]  s_axi_wstrb = 4'h1, cap_pin_in;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic        s_axi_arvalid = 0, s_axi_rready = 0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic        comparator_up_event, comparator_down_event;
	logic [5:0]  src = '0;
	int          mismatches = 0, checks = 0;

	dcc_top dcc_top_i (.clk, .reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cap_pin_in,
		.comparator_up_event, .comparator_down_event, .irq);
	dcc_src_model dcc_src_model_i (.clk, .want(src), .pin(cap_pin_in),
		.up_evt(comparator_up_event), .dn_evt(comparator_down_event));

	// 250 MHz clock
	initial forever #2 clk = ~clk;

	////////////////////////////////////////////////////////////////////
	// Compare and count
	task automatic chk(input logic [33:0] got, input logic [33:0] exp);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// Write one byte register; address and data offered together
	task automatic wr(input logic [7:0] ix, input logic [7:0] d,
		input logic [1:0] er = RESP_OKAY);
		int n;
		n = 0;
		s_axi_awaddr <= {2'h0, ix, 2'h0};
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge clk);
			n++;
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid && n < 50);
		// bready stays high between writes; a missing answer counts as a mismatch
		chk({31'h0, s_axi_bvalid, s_axi_bresp}, {31'h0, 1'b1, er});
	endtask : wr

	// Read one byte register and compare data and response
	task automatic rd(input logic [7:0] ix, input logic [7:0] ed,
		input logic [1:0] er = RESP_OKAY);
		int n;
		n = 0;
		s_axi_araddr <= {2'h0, ix, 2'h0};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge clk);
			n++;
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid && n < 50);
		// rready stays high between reads; a missing answer counts as a mismatch
		chk({33'h0, s_axi_rvalid}, 34'h1);
		chk({s_axi_rresp, s_axi_rdata}, {er, 24'h0, ed});
	endtask : rd

	// Report and stop
	task automatic end_of_test();
		$display("mismatches %0d checks %0d", mismatches, checks);
		if (mismatches == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : end_of_test

	////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		// All registers clear; 0xc0 and 0xc1 are holes
		for (int i = 'hba; i <= 'hc5; i++)
			rd(8'(i), 8'h00, (i == 'hc0 || i == 'hc1) ? RESP_SLVERR : RESP_OKAY);
		for (int k = 0; k < NUM_CAP; k++) begin
			rd(CAP_LO_IDX[k], 8'h00);
			rd(CAP_HI_IDX[k], 8'h00);
		end
		wr(8'hc0, 8'hff, RESP_SLVERR);
		// Low lane strobe clear: write answered but ignored
		s_axi_wstrb <= 4'h0;
		wr(IDX_RELOAD_HI, 8'hff);
		s_axi_wstrb <= 4'h1;
		rd(IDX_RELOAD_HI, 8'h00);
		// Prohibited tick code leaves the count still
		wr(IDX_COUNT_LO, 8'h34);
		wr(IDX_COUNT_HI, 8'h12);
		wr(IDX_CTRL, 8'h0f);
		repeat (20) @(posedge clk);
		rd(IDX_COUNT_LO, 8'h34);
		rd(IDX_COUNT_HI, 8'h12);
		// Divide by 1024 gives no tick within a short run
		wr(IDX_CTRL, 8'h0d);
		repeat (20) @(posedge clk);
		rd(IDX_COUNT_LO, 8'h34);
		// Divide by 2 ticks, but far too few times to borrow from the high byte
		wr(IDX_CTRL, 8'h03);
		repeat (20) @(posedge clk);
		rd(IDX_COUNT_HI, 8'h12);
		wr(IDX_CTRL, 8'h00);
		// Edge codes: pins 00,01,10,11; comparator up 01, down 00
		wr(IDX_EDGE_PIN, 8'he4);
		wr(IDX_EDGE_CMP, 8'h01);
		rd(IDX_EDGE_PIN, 8'he4);
		wr(IDX_CAP_IE, 8'h3f);
		// Disabled sources ignore a full toggle
		src <= 6'h3f;
		repeat (4) @(posedge clk);
		src <= 6'h00;
		repeat (4) @(posedge clk);
		rd(IDX_CAP_STS, 8'h00);
		// Rising edges at count 0x12aa, falling at 0x12bb
		wr(IDX_CAP_EN, 8'h3f);
		wr(IDX_COUNT_LO, 8'haa);
		src <= 6'h3f;
		repeat (4) @(posedge clk);
		rd(IDX_CAP_STS, 8'h1e);
		chk({33'h0, irq}, 34'h1);
		wr(IDX_COUNT_LO, 8'hbb);
		src <= 6'h00;
		repeat (4) @(posedge clk);
		rd(IDX_CAP_STS, 8'h3f);
		for (int k = 0; k < NUM_CAP; k++) begin
			rd(CAP_LO_IDX[k], ((8'h2d >> k) & 8'h1) != 0 ? 8'hbb : 8'haa);
			rd(CAP_HI_IDX[k], 8'h12);
		end
		// Status: a one leaves a bit, a zero clears it
		wr(IDX_CAP_STS, 8'h3e);
		rd(IDX_CAP_STS, 8'h3e);
		wr(IDX_CAP_IE, 8'h01);
		repeat (2) @(posedge clk);
		chk({33'h0, irq}, 34'h0);
		wr(IDX_CAP_STS, 8'h00);
		rd(IDX_CAP_STS, 8'h00);
		wr(CAP_LO_IDX[5], 8'h5a);
		rd(CAP_LO_IDX[5], 8'h5a);
		// Running counter hits zero, reloads and flags
		wr(IDX_RELOAD_LO, 8'h03);
		rd(IDX_RELOAD_LO, 8'h03);
		wr(IDX_COUNT_HI, 8'h00);
		wr(IDX_COUNT_LO, 8'h02);
		wr(IDX_CTRL, 8'h11);
		repeat (10) @(posedge clk);
		chk({33'h0, irq}, 34'h1);
		rd(IDX_CTRL, 8'h31);
		// Second write clears a flag set in the same cycle as the stop
		wr(IDX_CTRL, 8'h10);
		wr(IDX_CTRL, 8'h10);
		rd(IDX_CTRL, 8'h10);
		chk({33'h0, irq}, 34'h0);
		end_of_test();
	end

	// Watchdog against a hung bus
	initial begin
		repeat (20000) @(posedge clk);
		mismatches++;
		end_of_test();
	end
endmodule : dcc_top_test
